// ### shared/dsal_cfg.svh
`ifndef DSAL_CFG_SVH
`define DSAL_CFG_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define DSAL_ADR_CTRL      8'h00
`define DSAL_ADR_MODE      8'h04
`define DSAL_ADR_BERTH     8'h08
`define DSAL_ADR_BERCNT    8'h0C
`define DSAL_ADR_STAT      8'h10

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define DSAL_CTRL_AMUTE    0
`define DSAL_MODE_IF_LSB   0
`define DSAL_MODE_CH_LSB   4
`define DSAL_STAT_VLD_LSB  16
`define DSAL_CTRL_RST      1'b1
`define DSAL_BERTH_RST     16'h0010

// ----------------------------------------
// validity vector bits and mode masks
// ----------------------------------------
`define DSAL_V_MODEM       0
`define DSAL_V_SYNC        1
`define DSAL_V_CLK         2
`define DSAL_V_MAIN        3
`define DSAL_V_AUX         4
`define DSAL_V_DEMUX       5
`define DSAL_V_SYS         6
`define DSAL_IFM_MODEM     6'h1F
`define DSAL_IFM_ALL       6'h3F
`define DSAL_IFM_PROC      6'h3D
`define DSAL_CHM_ALL       12'hFBF
`define DSAL_CHM_AUX       12'h3B3
`define DSAL_CHM_DEMUX     12'h2B2

// ----------------------------------------
// timing
// ----------------------------------------
`define DSAL_CLK_MHZ       200
`define DSAL_CLK_TMO_NS    10000
`define DSAL_BER_WIN_US    1000
`define DSAL_ERR_HOLD_US   100
`define DSAL_CLK_TMO_CYC   ((`DSAL_CLK_TMO_NS * `DSAL_CLK_MHZ) / 1000)
`define DSAL_BER_WIN_CYC   (`DSAL_BER_WIN_US * `DSAL_CLK_MHZ)
`define DSAL_ERR_HOLD_CYC  (`DSAL_ERR_HOLD_US * `DSAL_CLK_MHZ)

`endif

// ### shared/dsal_pkg.sv
package dsal_pkg;

  // interface modes: 0..3, link and fractional-T1
  typedef enum logic [2:0] {
    DSAL_IF_0   = 3'h0,
    DSAL_IF_1   = 3'h1,
    DSAL_IF_2   = 3'h2,
    DSAL_IF_3   = 3'h3,
    DSAL_IF_STL = 3'h4,
    DSAL_IF_FT1 = 3'h5
  } dsal_if_mode_t;

  typedef logic [3:0] dsal_ch_mode_t;
  typedef logic [6:0] dsal_vld_t;

endpackage

// ### rtl/dsal_valid.sv
`timescale 1ns/1ps
`include "dsal_cfg.svh"

// ----------------------------------------
// mode validity decode
// ----------------------------------------
module dsal_valid
(
  input  wire dsal_pkg::dsal_if_mode_t if_mode_i,
  input  wire dsal_pkg::dsal_ch_mode_t chan_mode_i,
  output wire dsal_pkg::dsal_vld_t     vld_o
);

  // membership of a mode in a mask; codes past the mask are invalid
  function automatic logic in_if(input logic [2:0] m, input logic [5:0] msk);
    logic [7:0] ext;
    ext = {2'h0, msk};
    return ext[m];
  endfunction

  function automatic logic in_ch(input logic [3:0] m, input logic [11:0] msk);
    logic [15:0] ext;
    ext = {4'h0, msk};
    return ext[m];
  endfunction

  wire [2:0] ifm = if_mode_i;

  // an indication is meaningful only when both modes are valid
  assign vld_o[`DSAL_V_MODEM] = in_if(ifm, `DSAL_IFM_MODEM) & in_ch(chan_mode_i, `DSAL_CHM_ALL);
  assign vld_o[`DSAL_V_SYNC]  = in_if(ifm, `DSAL_IFM_ALL) & in_ch(chan_mode_i, `DSAL_CHM_ALL);
  assign vld_o[`DSAL_V_CLK]   = in_if(ifm, `DSAL_IFM_ALL) & in_ch(chan_mode_i, `DSAL_CHM_ALL);
  assign vld_o[`DSAL_V_MAIN]  = in_if(ifm, `DSAL_IFM_PROC) & in_ch(chan_mode_i, `DSAL_CHM_ALL);
  assign vld_o[`DSAL_V_AUX]   = in_if(ifm, `DSAL_IFM_PROC) & in_ch(chan_mode_i, `DSAL_CHM_AUX);
  assign vld_o[`DSAL_V_DEMUX] = in_if(ifm, `DSAL_IFM_PROC) & in_ch(chan_mode_i, `DSAL_CHM_DEMUX);
  assign vld_o[`DSAL_V_SYS]   = in_if(ifm, `DSAL_IFM_ALL) & in_ch(chan_mode_i, `DSAL_CHM_ALL);

endmodule

// ### rtl/dsal_top.sv
// Operation
// - main fault low while main left processor lost sync or failed, any mode
// - clock fault low whenever the master data clock stops
// - modem signal loss drives its alarm low and mutes audio
// - mute status output low while muted, high otherwise
// - loss of recovered-clock sync drives its alarm low and mutes audio
// - mute relay energized only when powered and free of modem, sync, system and error-rate alarms
// - while mute-override input is low, no automatic muting
// - data-error output low when received data errors are detected
// - error-rate flag low above programmable threshold; auto-mute selectable
// - aux fault low when first aux processor fails or loses sync
// - demultiplexer fault low on frame sync loss, any mode
// - system fault is OR of clock, left and right main, both aux and demux faults; mutes
// - system fault counts only alarms relevant to the configured mode
// - every fault output stays driven in all modes
`timescale 1ns/1ps
`include "dsal_cfg.svh"

module dsal_top
#(
  parameter int BER_WIN_CYC  = `DSAL_BER_WIN_CYC,
  parameter int ERR_HOLD_CYC = `DSAL_ERR_HOLD_CYC
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        modem_low_i,
  input  wire logic        sync_lost_i,
  input  wire logic        data_clk_i,
  input  wire logic        main_l_fail_i,
  input  wire logic        main_r_fail_i,
  input  wire logic        aux1_fail_i,
  input  wire logic        aux2_fail_i,
  input  wire logic        demux_lost_i,
  input  wire logic        err_evt_i,
  input  wire logic        mute_dis_n_i,
  output logic             main_flt_n_o,
  output logic             clk_flt_n_o,
  output logic             modem_loss_n_o,
  output logic             mute_n_o,
  output logic             sync_loss_n_o,
  output logic             relay_en_o,
  output logic             data_err_n_o,
  output logic             ber_flag_n_o,
  output logic             aux_flt_n_o,
  output logic             demux_flt_n_o,
  output logic             sys_flt_n_o,
  output logic             audio_mute_o
);

  localparam int CLK_TMO = `DSAL_CLK_TMO_CYC;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic                    amute_en_r;
  dsal_pkg::dsal_if_mode_t if_mode_r;
  dsal_pkg::dsal_ch_mode_t chan_mode_r;
  logic [15:0]             ber_th_r;
  logic [15:0]             ber_cnt_r;
  logic [15:0]             err_acc_r;
  logic [19:0]             win_cnt_r;
  logic [19:0]             hold_cnt_r;
  logic [11:0]             clk_cnt_r;
  logic                    dclk_d_r;
  logic                    ack_r;
  logic [31:0]             dat_r;
  logic                    ber_r;
  logic [11:0]             alarm_r;
  dsal_pkg::dsal_vld_t     vld;

  // ----------------------------------------
  // mode validity
  // ----------------------------------------
  dsal_valid dsal_valid_inst
  (
    .if_mode_i   (if_mode_r),
    .chan_mode_i (chan_mode_r),
    .vld_o       (vld)
  );

  // ----------------------------------------
  // wishbone decode
  // ----------------------------------------
  wire bus_take = wb_cyc_i & wb_stb_i & ~ack_r;
  wire bus_wr   = bus_take & wb_we_i;
  wire sel_ctrl = wb_adr_i == `DSAL_ADR_CTRL;
  wire sel_mode = wb_adr_i == `DSAL_ADR_MODE;
  wire sel_th   = wb_adr_i == `DSAL_ADR_BERTH;
  wire sel_cnt  = wb_adr_i == `DSAL_ADR_BERCNT;
  wire sel_stat = wb_adr_i == `DSAL_ADR_STAT;
  wire wr_ctrl  = bus_wr & sel_ctrl & wb_sel_i[0];
  wire wr_mode  = bus_wr & sel_mode & wb_sel_i[0];
  wire wr_th_lo = bus_wr & sel_th & wb_sel_i[0];
  wire wr_th_hi = bus_wr & sel_th & wb_sel_i[1];

  // ack one cycle after the request; unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= bus_take;
  end

  // configuration writes; mode codes past the table are stored as written
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      amute_en_r  <= `DSAL_CTRL_RST;
      if_mode_r   <= dsal_pkg::DSAL_IF_0;
      chan_mode_r <= 4'h0;
      ber_th_r    <= `DSAL_BERTH_RST;
    end
    else
    begin
      if (wr_ctrl)
        amute_en_r <= wb_dat_i[`DSAL_CTRL_AMUTE];
      if (wr_mode)
      begin
        if_mode_r   <= dsal_pkg::dsal_if_mode_t'(wb_dat_i[`DSAL_MODE_IF_LSB +: 3]);
        chan_mode_r <= wb_dat_i[`DSAL_MODE_CH_LSB +: 4];
      end
      if (wr_th_lo)
        ber_th_r[7:0] <= wb_dat_i[7:0];
      if (wr_th_hi)
        ber_th_r[15:8] <= wb_dat_i[15:8];
    end
  end

  // read mux; status shows active-high alarms and the validity vector
  wire [31:0] rd_mux =
    sel_ctrl ? {31'h0, amute_en_r} :
    sel_mode ? {24'h0, chan_mode_r, 1'b0, if_mode_r} :
    sel_th   ? {16'h0, ber_th_r} :
    sel_cnt  ? {16'h0, ber_cnt_r} :
    sel_stat ? {9'h0, vld, 4'h0, alarm_r} : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_r <= 32'h0;
    else if (bus_take & ~wb_we_i)
      dat_r <= rd_mux;
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ----------------------------------------
  // master data clock watchdog
  // ----------------------------------------
  // the data clock is sampled as a plain level; any change restarts the count
  wire dclk_edge = data_clk_i ^ dclk_d_r;
  wire clk_dead  = clk_cnt_r >= 12'(CLK_TMO);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dclk_d_r  <= 1'b0;
      clk_cnt_r <= 12'h000;
    end
    else
    begin
      dclk_d_r <= data_clk_i;
      if (dclk_edge)
        clk_cnt_r <= 12'h000;
      else if (!clk_dead)
        clk_cnt_r <= clk_cnt_r + 12'h001;
    end
  end

  // ----------------------------------------
  // error-rate measurement
  // ----------------------------------------
  // errors are counted over a fixed window; the flag updates at window end,
  // so it lags a burst by up to one window but never flickers mid-window
  wire        win_end = win_cnt_r == 20'(BER_WIN_CYC - 1);
  wire [15:0] acc_nxt = (err_evt_i && err_acc_r != 16'hFFFF) ? err_acc_r + 16'h0001 : err_acc_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      win_cnt_r <= 20'h00000;
      err_acc_r <= 16'h0000;
      ber_cnt_r <= 16'h0000;
      ber_r     <= 1'b0;
    end
    else if (win_end)
    begin
      win_cnt_r <= 20'h00000;
      err_acc_r <= 16'h0000;
      ber_cnt_r <= acc_nxt;
      ber_r     <= acc_nxt > ber_th_r;
    end
    else
    begin
      win_cnt_r <= win_cnt_r + 20'h00001;
      err_acc_r <= acc_nxt;
    end
  end

  // data error indication is stretched so a single error stays visible
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hold_cnt_r <= 20'h00000;
    else if (err_evt_i)
      hold_cnt_r <= 20'(ERR_HOLD_CYC);
    else if (hold_cnt_r != 20'h00000)
      hold_cnt_r <= hold_cnt_r - 20'h00001;
  end

  // ----------------------------------------
  // alarm combination
  // ----------------------------------------
  // individual alarms ignore the modes; only the system sum is masked
  wire main_a  = main_l_fail_i;
  wire aux_a   = aux1_fail_i;
  wire demux_a = demux_lost_i;
  wire derr_a  = err_evt_i | (hold_cnt_r != 20'h00000);
  wire sys_a   = (clk_dead & vld[`DSAL_V_CLK]) |
                 ((main_l_fail_i | main_r_fail_i) & vld[`DSAL_V_MAIN]) |
                 ((aux1_fail_i | aux2_fail_i) & vld[`DSAL_V_AUX]) |
                 (demux_lost_i & vld[`DSAL_V_DEMUX]);
  wire mute_req = modem_low_i | sync_lost_i | sys_a | (ber_r & amute_en_r);
  wire mute_a   = mute_req & mute_dis_n_i;
  wire fault_a  = modem_low_i | sync_lost_i | sys_a | ber_r;

  // bit order of alarm_r matches the status register
  wire [11:0] alarm_nxt = {sys_a, demux_a, aux_a, ber_r, derr_a, mute_dis_n_i,
                           ~fault_a, sync_lost_i, mute_a, modem_low_i, clk_dead, main_a};

  // all alarm, mute and relay outputs come from this one register; reset parks them muted, relay off
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      alarm_r <= 12'h008;
    else
      alarm_r <= alarm_nxt;
  end

  assign main_flt_n_o   = ~alarm_r[0];
  assign clk_flt_n_o    = ~alarm_r[1];
  assign modem_loss_n_o = ~alarm_r[2];
  assign mute_n_o       = ~alarm_r[3];
  assign sync_loss_n_o  = ~alarm_r[4];
  assign relay_en_o     = alarm_r[5];
  assign data_err_n_o   = ~alarm_r[7];
  assign ber_flag_n_o   = ~alarm_r[8];
  assign aux_flt_n_o    = ~alarm_r[9];
  assign demux_flt_n_o  = ~alarm_r[10];
  assign sys_flt_n_o    = ~alarm_r[11];
  assign audio_mute_o   = alarm_r[3];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_main;
    main_l_fail_i |=> !main_flt_n_o;
  endproperty
  a_main: assert property (p_main) else $error("main fault not raised");

  property p_clk;
    !dclk_edge [*3] ##0 (clk_cnt_r == 12'(CLK_TMO - 1)) |=> ##1 !clk_flt_n_o;
  endproperty
  a_clk: assert property (p_clk) else $error("clock fault missed after timeout");

  property p_clk_ok;
    dclk_edge |=> ##1 clk_flt_n_o;
  endproperty
  a_clk_ok: assert property (p_clk_ok) else $error("clock fault while data clock toggles");

  property p_modem;
    (modem_low_i && mute_dis_n_i) |=> (!modem_loss_n_o && audio_mute_o);
  endproperty
  a_modem: assert property (p_modem) else $error("modem loss not flagged or not muted");

  property p_mute_pin;
    !mute_req |=> (mute_n_o && !audio_mute_o);
  endproperty
  a_mute_pin: assert property (p_mute_pin) else $error("mute status low without a mute cause");

  property p_sync;
    (sync_lost_i && mute_dis_n_i) |=> (!sync_loss_n_o && !mute_n_o);
  endproperty
  a_sync: assert property (p_sync) else $error("sync loss not flagged or not muted");

  property p_relay;
    relay_en_o |-> (modem_loss_n_o && sync_loss_n_o && sys_flt_n_o && ber_flag_n_o);
  endproperty
  a_relay: assert property (p_relay) else $error("relay energized during a fault");

  property p_ovr;
    !mute_dis_n_i |=> !audio_mute_o;
  endproperty
  a_ovr: assert property (p_ovr) else $error("muted despite override");

  property p_derr;
    err_evt_i |=> !data_err_n_o [*2];
  endproperty
  a_derr: assert property (p_derr) else $error("data error not held");

  property p_ber;
    (win_end && acc_nxt > ber_th_r) |=> (ber_cnt_r == $past(acc_nxt)) ##1 !ber_flag_n_o;
  endproperty
  a_ber: assert property (p_ber) else $error("error-rate flag not raised");

  property p_ber_mute;
    (ber_r && amute_en_r && mute_dis_n_i) |=> (audio_mute_o && !mute_n_o);
  endproperty
  a_ber_mute: assert property (p_ber_mute) else $error("error-rate auto-mute missing");

  property p_aux;
    aux1_fail_i |=> !aux_flt_n_o;
  endproperty
  a_aux: assert property (p_aux) else $error("aux fault not raised");

  property p_demux_any;
    (demux_lost_i && !vld[`DSAL_V_DEMUX]) |=> !demux_flt_n_o;
  endproperty
  a_demux_any: assert property (p_demux_any) else $error("demux fault masked by mode");

  property p_sys;
    (aux2_fail_i && vld[`DSAL_V_AUX] && mute_dis_n_i) |=> (!sys_flt_n_o && audio_mute_o);
  endproperty
  a_sys: assert property (p_sys) else $error("system fault not raised");

  property p_sys_mask;
    (!vld[`DSAL_V_DEMUX] && !vld[`DSAL_V_AUX] && !vld[`DSAL_V_MAIN] && !vld[`DSAL_V_CLK]) |=> sys_flt_n_o;
  endproperty
  a_sys_mask: assert property (p_sys_mask) else $error("irrelevant alarm reached system fault");

  property p_main_any;
    (main_l_fail_i && !vld[`DSAL_V_MAIN]) |=> !main_flt_n_o;
  endproperty
  a_main_any: assert property (p_main_any) else $error("main fault masked by mode");

  c_modem_mute: cover property (modem_low_i && mute_dis_n_i ##1 audio_mute_o);
  c_ovr:        cover property (sync_lost_i && !mute_dis_n_i ##1 !sync_loss_n_o && !audio_mute_o);
  c_ber:        cover property (win_end && acc_nxt > ber_th_r ##2 !ber_flag_n_o);
  c_sys_mask:   cover property (demux_lost_i && !vld[`DSAL_V_DEMUX] ##1 sys_flt_n_o && !demux_flt_n_o);

endmodule

// ### test/dsal_sup_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// supervisory equipment on the status port
// ----------------------------------------
module dsal_sup_model
(
  input  wire logic       clk_i,
  input  wire logic       ovr_req_i,
  input  wire logic [2:0] if_mode_i,
  input  wire logic [3:0] ch_mode_i,
  input  wire logic       modem_loss_n_i,
  input  wire logic       main_flt_n_i,
  input  wire logic       aux_flt_n_i,
  input  wire logic       demux_flt_n_i,
  output logic            mute_dis_n_o,
  output logic [3:0]      trusted_o
);
  // an alarm is only believed where both modes make it meaningful
  wire ch_ok  = (ch_mode_i != 4'h6) && (ch_mode_i < 4'hC);
  wire prc_ok = (if_mode_i != 3'h1) && (if_mode_i < 3'h6) && ch_ok;
  assign trusted_o[0] = ~modem_loss_n_i & (if_mode_i < 3'h5) & ch_ok;
  assign trusted_o[1] = ~main_flt_n_i & prc_ok;
  assign trusted_o[2] = ~aux_flt_n_i & prc_ok & (ch_mode_i inside {0, 1, 4, 5, 7, 8, 9});
  assign trusted_o[3] = ~demux_flt_n_i & prc_ok & (ch_mode_i inside {1, 4, 5, 7, 9});

  // contact closure to ground overrides muting; only moved on a clock edge
  always @(posedge clk_i)
    mute_dis_n_o <= ~ovr_req_i;
endmodule

// ### test/dsal_top_test.sv
`timescale 1ns/1ps
`include "dsal_cfg.svh"

module dsal_top_test;
  localparam int WIN  = 64;
  localparam int HOLD = 8;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic        we = 1'b0, cyc = 1'b0, stb = 1'b0, ack;
  logic        modem = 1'b0, sync = 1'b0, dclk = 1'b0, ml = 1'b0, mr = 1'b0;
  logic        a1 = 1'b0, a2 = 1'b0, dm = 1'b0, err = 1'b0, ovr = 1'b0, ovr_n;
  logic        run = 1'b1, snap = 1'b0, en = 1'b1, clkf = 1'b0, berf = 1'b0, derr = 1'b0;
  logic        main_n, clkf_n, mdm_n, mute_n, sync_n, relay, derr_n, ber_n, aux_n, dmx_n, sys_n, amute;
  logic [2:0]  ifm = 3'h0;
  logic [3:0]  chm = 4'h0;
  wire  [11:0] pins;
  wire  [3:0]  trust;
  logic [3:0]  sel = 4'h0;
  int          n_fail = 0;
  int          num_checks = 0;
  logic [31:0] rd_q[$];
  logic [15:0] pin_q[$];

  assign pins = {~sys_n, ~dmx_n, ~aux_n, ~ber_n, ~derr_n, amute, relay, ~sync_n, ~mute_n, ~mdm_n, ~clkf_n, ~main_n};

  dsal_top #(.BER_WIN_CYC(WIN), .ERR_HOLD_CYC(HOLD)) dsal_top_inst
  (
    .clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .modem_low_i(modem),
    .sync_lost_i(sync), .data_clk_i(dclk), .main_l_fail_i(ml), .main_r_fail_i(mr), .aux1_fail_i(a1),
    .aux2_fail_i(a2), .demux_lost_i(dm), .err_evt_i(err), .mute_dis_n_i(ovr_n), .main_flt_n_o(main_n),
    .clk_flt_n_o(clkf_n), .modem_loss_n_o(mdm_n), .mute_n_o(mute_n), .sync_loss_n_o(sync_n),
    .relay_en_o(relay), .data_err_n_o(derr_n), .ber_flag_n_o(ber_n), .aux_flt_n_o(aux_n),
    .demux_flt_n_o(dmx_n), .sys_flt_n_o(sys_n), .audio_mute_o(amute)
  );

  dsal_sup_model dsal_sup_model_inst
  (
    .clk_i(clk), .ovr_req_i(ovr), .if_mode_i(ifm), .ch_mode_i(chm), .modem_loss_n_i(mdm_n),
    .main_flt_n_i(main_n), .aux_flt_n_i(aux_n), .demux_flt_n_i(dmx_n), .mute_dis_n_o(ovr_n),
    .trusted_o(trust)
  );

  // ----------------------------------------
  // clocks, expectations and checking
  // ----------------------------------------
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  // data clock toggles every cycle unless a stall is being staged
  always @(posedge clk)
    if (run) dclk <= ~dclk;

  // expected status word, built from the modes and the staged faults
  function automatic logic [31:0] stat_exp();
    logic       ch_ok, prc, sys, mute;
    logic [6:0] v;
    ch_ok = (chm != 4'h6) && (chm < 4'hC);
    prc = (ifm != 3'h1) && (ifm < 3'h6) && ch_ok;
    v[0] = (ifm < 3'h5) && ch_ok;
    v[1] = (ifm < 3'h6) && ch_ok;
    v[2] = v[1];
    v[3] = prc;
    v[4] = prc && (chm inside {0, 1, 4, 5, 7, 8, 9});
    v[5] = prc && (chm inside {1, 4, 5, 7, 9});
    v[6] = v[1];
    sys = (clkf & v[2]) | ((ml | mr) & v[3]) | ((a1 | a2) & v[4]) | (dm & v[5]);
    mute = (modem | sync | sys | (berf & en)) & ~ovr;
    return {9'h0, v, 4'h0, sys, dm, a1, berf, derr, ~ovr, ~(modem | sync | sys | berf), sync, mute, modem, clkf, ml};
  endfunction

  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error t=%0t expected %h got %h", $time, e, g);
    end
  endtask

  // the oldest note is taken whenever a read answer or a pin snapshot appears
  always @(posedge clk)
  begin
    if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0)
      cmp(rd_q.pop_front(), rdat);
    if (snap)
      cmp({16'h0, pin_q.pop_front()}, {16'h0, trust, pins});
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    @(posedge clk);
    while (ack !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    if (n >= 40)
    begin
      n_fail++;
      $display("Error t=%0t bus answer missing", $time);
    end
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic chk();
    logic [31:0] s;
    s = stat_exp();
    // observer trust: alarm shown on its pin and both modes valid
    pin_q.push_back({s[10] & s[21], s[9] & s[20], s[0] & s[19], s[2] & s[16], s[11:7], s[3], s[5:0]});
    snap <= 1'b1;
    @(posedge clk);
    snap <= 1'b0;
  endtask

  task wrap_up();
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    logic [31:0] r;
    int          n;
    r = $urandom(32'hce03d84a);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`DSAL_ADR_CTRL, 32'h1);
    rd(`DSAL_ADR_MODE, 32'h0);
    rd(`DSAL_ADR_BERTH, 32'h10);
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h0);
    bus(1'b1, `DSAL_ADR_STAT, 32'hFFFFFFFF);
    rd(`DSAL_ADR_STAT, stat_exp());
    // sparse random faults over random modes; masking shows in sys only
    repeat (60)
    begin
      r = $urandom;
      ifm = r[26:24];
      chm = r[31:28];
      bus(1'b1, `DSAL_ADR_MODE, {24'h0, chm, 1'b0, ifm});
      {modem, sync, ml, mr, a1, a2, dm, ovr} <= r[7:0] & r[15:8] & r[23:16];
      repeat (3) @(posedge clk);
      chk();
      rd(`DSAL_ADR_STAT, stat_exp());
    end
    {modem, sync, ml, mr, a1, a2, dm, ovr} <= 8'h00;
    ifm = 3'h0;
    chm = 4'h0;
    bus(1'b1, `DSAL_ADR_MODE, 32'h0);
    // stalled data clock, then the same fault under an unused channel mode
    run <= 1'b0;
    repeat (2010) @(posedge clk);
    clkf = 1'b1;
    chk();
    chm = 4'hC;
    bus(1'b1, `DSAL_ADR_MODE, 32'hC0);
    chk();
    run <= 1'b1;
    repeat (5) @(posedge clk);
    clkf = 1'b0;
    chk();
    chm = 4'h0;
    bus(1'b1, `DSAL_ADR_MODE, 32'h0);
    // a single error is stretched, then released
    err <= 1'b1;
    @(posedge clk);
    err <= 1'b0;
    repeat (2) @(posedge clk);
    derr = 1'b1;
    chk();
    repeat (HOLD + 6) @(posedge clk);
    derr = 1'b0;
    chk();
    // error burst over a low threshold, with and without auto-mute
    bus(1'b1, `DSAL_ADR_BERTH, 32'h3);
    err <= 1'b1;
    repeat (30) @(posedge clk);
    err <= 1'b0;
    n = 0;
    while (ber_n !== 1'b0 && n < 3 * WIN)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 3 * WIN)
    begin
      n_fail++;
      $display("Error t=%0t error-rate flag never rose", $time);
    end
    repeat (HOLD + 8) @(posedge clk);
    berf = 1'b1;
    chk();
    en = 1'b0;
    bus(1'b1, `DSAL_ADR_CTRL, 32'h0);
    chk();
    repeat (2 * WIN + 4) @(posedge clk);
    berf = 1'b0;
    chk();
    wrap_up();
  end

  // a hang counts as a mismatch and ends the run through the same task
  initial
  begin
    #(20000 * 5);
    n_fail++;
    $display("Error t=%0t run did not finish", $time);
    wrap_up();
  end
endmodule
